// *** tcl_host.sv ***
// Host controller that drives the two-way tag comparator through its pins
//
// Operation
// - Data RAM use: manual mode, clears inactive.
// - Controller forces one tag bit high.
// - Controller master-resets device after power-up.
// - Every entry-clear pulse in manual mode, tag bus released.
// - Drop recency strobe only after hits settle.
// - Store strobe writes tag, diagnostic bad parity.
`timescale 1ns/1ps
module tcl_host (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic      [12:0] index_in,
  output logic      [3:0]  tag_bus_out,
  output logic             tag_bus_oe,
  input  wire logic [3:0]  tag_bus_in,
  output logic             chip_enable_n,
  output logic             output_enable_n,
  output logic             store_strobe_n,
  output logic             auto_way_choice,
  output logic             way_select_input,
  output logic             entry_clear_n,
  output logic             recency_update_strobe,
  output logic             device_reset_n,
  input  wire logic        hit_way_one,
  input  wire logic        hit_way_two,
  input  wire logic        parity_fault_n,
  input  wire logic        way_indicator
);
  typedef enum logic [2:0] {S_INIT, S_IDLE, S_SETUP, S_ACT, S_HOLD} tcl_state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Tag as applied to the pins, with the valid flag forced when enabled
  // valid flag forced
  function automatic logic [3:0] pick_tag(input logic [3:0] t, input logic v);
    logic [3:0] r;
    r = t;
    if (v) begin
      r[tcl_pkg::VALID_BIT] = 1'b1;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Synchronised device outputs
  // ----------------------------------------------------------------
  tcl_sync_if sif ();
  assign sif.pins = {tag_bus_in, way_indicator, parity_fault_n, hit_way_two, hit_way_one};

  tcl_sync u_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .sif     (sif)
  );

  logic       s_hit1;
  logic       s_hit2;
  logic       s_fault_n;
  logic       s_way;
  logic [3:0] s_tag;
  assign s_hit1    = sif.sync[0];
  assign s_hit2    = sif.sync[1];
  assign s_fault_n = sif.sync[2];
  assign s_way     = sif.sync[3];
  assign s_tag     = sif.sync[7:4];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tcl_state_t      state,     next_state;
  logic [3:0]      cnt,       next_cnt;
  tcl_pkg::tcl_op_t op,       next_op;
  logic            c_auto,    next_c_auto;
  logic            c_way,     next_c_way;
  logic            c_badpar,  next_c_badpar;
  logic            c_lruupd,  next_c_lruupd;
  logic [12:0]     r_index,   next_r_index;
  logic [3:0]      r_tag,     next_r_tag;
  logic            r_valid,   next_r_valid;
  logic            init_done, next_init_done;
  logic            st_hit1,   next_st_hit1;
  logic            st_hit2,   next_st_hit2;
  logic            st_fault,  next_st_fault;
  logic            st_way,    next_st_way;
  logic [3:0]      st_tag,    next_st_tag;
  logic [31:0]     next_reg_rdata;
  logic [12:0]     next_index_in;
  logic [3:0]      next_tag_out;
  logic            next_tag_oe;
  logic            next_ce_n;
  logic            next_oe_n;
  logic            next_store_n;
  logic            next_auto;
  logic            next_wsel;
  logic            next_clr_n;
  logic            next_lru;
  logic            next_dev_rst_n;
  logic            cmd_ok;
  logic            busy;

  assign busy = (state != S_IDLE);

  // Commands are taken only when idle; before init only master reset
  assign cmd_ok = reg_wr && (reg_addr == tcl_pkg::REG_CMD) && !busy &&
                  (init_done || (reg_wdata[2:0] == tcl_pkg::OP_MRESET));

  // ----------------------------------------------------------------
  // Register file and sequencer, next values
  // ----------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_op        = op;
    next_c_auto    = c_auto;
    next_c_way     = c_way;
    next_c_badpar  = c_badpar;
    next_c_lruupd  = c_lruupd;
    next_r_index   = r_index;
    next_r_tag     = r_tag;
    next_r_valid   = r_valid;
    next_init_done = init_done;
    next_st_hit1   = st_hit1;
    next_st_hit2   = st_hit2;
    next_st_fault  = st_fault;
    next_st_way    = st_way;
    next_st_tag    = st_tag;
    next_index_in  = index_in;
    next_tag_out   = tag_bus_out;
    next_tag_oe    = tag_bus_oe;
    next_ce_n      = chip_enable_n;
    next_oe_n      = output_enable_n;
    next_store_n   = store_strobe_n;
    next_auto      = auto_way_choice;
    next_wsel      = way_select_input;
    next_clr_n     = entry_clear_n;
    next_lru       = recency_update_strobe;
    next_dev_rst_n = device_reset_n;

    // Software writes to configuration registers
    if (reg_wr && !busy) begin
      if (reg_addr == tcl_pkg::REG_INDEX) begin
        next_r_index = reg_wdata[12:0];
      end
      if (reg_addr == tcl_pkg::REG_TAG) begin
        next_r_tag = reg_wdata[3:0];
      end
      if (reg_addr == tcl_pkg::REG_CFG) begin
        next_r_valid = reg_wdata[0];
      end
    end

    // Read data stand in the cycle after the strobe
    next_reg_rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        tcl_pkg::REG_CMD: begin
          next_reg_rdata[2:0] = op;
          next_reg_rdata[tcl_pkg::CMD_AUTO]   = c_auto;
          next_reg_rdata[tcl_pkg::CMD_WAY]    = c_way;
          next_reg_rdata[tcl_pkg::CMD_BADPAR] = c_badpar;
          next_reg_rdata[tcl_pkg::CMD_LRUUPD] = c_lruupd;
        end
        tcl_pkg::REG_INDEX: next_reg_rdata[12:0] = r_index;
        tcl_pkg::REG_TAG:   next_reg_rdata[3:0]  = r_tag;
        tcl_pkg::REG_CFG:   next_reg_rdata[0]    = r_valid;
        tcl_pkg::REG_STATUS: begin
          next_reg_rdata[tcl_pkg::ST_BUSY]     = busy;
          next_reg_rdata[tcl_pkg::ST_INITDONE] = init_done;
          next_reg_rdata[tcl_pkg::ST_HIT1]     = st_hit1;
          next_reg_rdata[tcl_pkg::ST_HIT2]     = st_hit2;
          next_reg_rdata[tcl_pkg::ST_PFAULT]   = st_fault;
          next_reg_rdata[tcl_pkg::ST_WAY]      = st_way;
          next_reg_rdata[tcl_pkg::ST_RDTAG +: 4] = st_tag;
        end
        default: next_reg_rdata = 32'h0000_0000;
      endcase
    end

    case (state)
      S_INIT: begin
        next_op    = tcl_pkg::OP_MRESET;
        next_cnt   = 4'h0;
        next_state = S_SETUP;
      end

      S_IDLE: begin
        if (cmd_ok && (reg_wdata[2:0] != tcl_pkg::OP_NOP)) begin
          next_op       = tcl_pkg::tcl_op_t'(reg_wdata[2:0]);
          next_c_auto   = reg_wdata[tcl_pkg::CMD_AUTO];
          next_c_way    = reg_wdata[tcl_pkg::CMD_WAY];
          next_c_badpar = reg_wdata[tcl_pkg::CMD_BADPAR];
          next_c_lruupd = reg_wdata[tcl_pkg::CMD_LRUUPD];
          next_cnt      = 4'h0;
          next_state    = S_SETUP;
        end
      end

      // Present index, tag and mode, then wait for the hits to settle
      S_SETUP: begin
        next_index_in = r_index;
        next_cnt      = cnt + 4'h1;
        case (op)
          tcl_pkg::OP_COMPARE: begin
            next_ce_n    = 1'b0;
            next_tag_out = pick_tag(r_tag, r_valid);
            next_tag_oe  = 1'b1;
            next_auto    = 1'b1;
          end
          tcl_pkg::OP_WRITE: begin
            next_ce_n    = 1'b0;
            next_tag_out = pick_tag(r_tag, r_valid);
            next_tag_oe  = 1'b1;
            next_auto    = c_auto;
            next_wsel    = c_way;
          end
          tcl_pkg::OP_READ: begin
            next_ce_n = 1'b0;
            next_auto = 1'b0;
            next_wsel = c_way;
            next_oe_n = 1'b0;
          end
          tcl_pkg::OP_CLEAR: begin
            next_ce_n = 1'b0;
            next_auto = 1'b0;
            next_wsel = c_way;
          end
          default: next_ce_n = 1'b1;
        endcase
        if (cnt == tcl_pkg::SETTLE_CYC - 4'h1) begin
          next_cnt = 4'h0;
          if (op == tcl_pkg::OP_COMPARE) begin
            next_st_hit1  = s_hit1;
            next_st_hit2  = s_hit2;
            next_st_fault = !s_fault_n;
            next_st_way   = s_way;
            if (c_lruupd && (s_hit1 || s_hit2)) begin
              next_lru   = 1'b0;
              next_state = S_ACT;
            end else begin
              next_state = S_HOLD;
            end
          end else if (op == tcl_pkg::OP_READ) begin
            next_st_tag   = s_tag;
            next_st_fault = !s_fault_n;
            next_state    = S_HOLD;
          end else begin
            // diagnostic bad parity, read enable only under the strobe
            next_oe_n      = !((op == tcl_pkg::OP_WRITE) && c_badpar);
            next_store_n   = !(op == tcl_pkg::OP_WRITE);
            next_clr_n     = !(op == tcl_pkg::OP_CLEAR);
            next_dev_rst_n = !(op == tcl_pkg::OP_MRESET);
            next_state     = S_ACT;
          end
        end
      end

      // Hold the strobe low for its least width
      S_ACT: begin
        next_cnt = cnt + 4'h1;
        if (op == tcl_pkg::OP_WRITE) begin
          next_st_way = s_way;
        end
        if (cnt == tcl_pkg::STROBE_CYC - 4'h1) begin
          next_cnt       = 4'h0;
          next_store_n   = 1'b1;
          next_oe_n      = 1'b1;  // Device must not drive while our tag still stands
          next_clr_n     = 1'b1;
          next_lru       = 1'b1;
          next_dev_rst_n = 1'b1;
          next_state     = S_HOLD;
        end
      end

      // Release the pins and deselect; tag released in the same cycle as mode changes
      S_HOLD: begin
        next_tag_oe = 1'b0;
        next_oe_n   = 1'b1;
        next_ce_n   = 1'b1;
        next_auto   = 1'b0;
        next_state  = S_IDLE;
        if (op == tcl_pkg::OP_MRESET) begin
          next_init_done = 1'b1;
        end
      end

      default: next_state = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // All pin drivers come straight from flip-flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state                 <= S_INIT;
      cnt                   <= 4'h0;
      op                    <= tcl_pkg::OP_NOP;
      c_auto                <= 1'b0;
      c_way                 <= 1'b0;
      c_badpar              <= 1'b0;
      c_lruupd              <= 1'b0;
      r_index               <= tcl_pkg::INDEX_RST;
      r_tag                 <= tcl_pkg::TAG_RST;
      r_valid               <= tcl_pkg::CFG_VALID_RST;
      init_done             <= 1'b0;
      st_hit1               <= 1'b0;
      st_hit2               <= 1'b0;
      st_fault              <= 1'b0;
      st_way                <= 1'b0;
      st_tag                <= 4'h0;
      reg_rdata             <= 32'h0000_0000;
      index_in              <= tcl_pkg::INDEX_RST;
      tag_bus_out           <= 4'h0;
      tag_bus_oe            <= 1'b0;
      chip_enable_n         <= 1'b1;
      output_enable_n       <= 1'b1;
      store_strobe_n        <= 1'b1;
      auto_way_choice       <= 1'b0;
      way_select_input      <= 1'b0;
      entry_clear_n         <= 1'b1;
      recency_update_strobe <= 1'b1;
      device_reset_n        <= 1'b1;
    end else begin
      state                 <= next_state;
      cnt                   <= next_cnt;
      op                    <= next_op;
      c_auto                <= next_c_auto;
      c_way                 <= next_c_way;
      c_badpar              <= next_c_badpar;
      c_lruupd              <= next_c_lruupd;
      r_index               <= next_r_index;
      r_tag                 <= next_r_tag;
      r_valid               <= next_r_valid;
      init_done             <= next_init_done;
      st_hit1               <= next_st_hit1;
      st_hit2               <= next_st_hit2;
      st_fault              <= next_st_fault;
      st_way                <= next_st_way;
      st_tag                <= next_st_tag;
      reg_rdata             <= next_reg_rdata;
      index_in              <= next_index_in;
      tag_bus_out           <= next_tag_out;
      tag_bus_oe            <= next_tag_oe;
      chip_enable_n         <= next_ce_n;
      output_enable_n       <= next_oe_n;
      store_strobe_n        <= next_store_n;
      auto_way_choice       <= next_auto;
      way_select_input      <= next_wsel;
      entry_clear_n         <= next_clr_n;
      recency_update_strobe <= next_lru;
      device_reset_n        <= next_dev_rst_n;
    end
  end
endmodule

// *** tcl_pkg.sv ***
// Package of constants for the two-way tag comparator host controller
package tcl_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 100;  // clk_sys period
  localparam int MATCH_NS     = 17;   // index to hit settle time
  localparam int STROBE_NS    = 200;  // least strobe low width
  localparam int SYNC_STAGES  = 2;
  localparam int MATCH_CYC_I  = (MATCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC_I = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] SETTLE_CYC = 4'(MATCH_CYC_I + SYNC_STAGES + 1);
  localparam logic [3:0] STROBE_CYC = 4'(STROBE_CYC_I < 1 ? 1 : STROBE_CYC_I);

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_INDEX  = 8'h04;
  localparam logic [7:0] REG_TAG    = 8'h08;
  localparam logic [7:0] REG_CFG    = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CMD_AUTO    = 3;
  localparam int CMD_WAY     = 4;
  localparam int CMD_BADPAR  = 5;
  localparam int CMD_LRUUPD  = 6;
  localparam int ST_BUSY     = 0;
  localparam int ST_INITDONE = 1;
  localparam int ST_HIT1     = 2;
  localparam int ST_HIT2     = 3;
  localparam int ST_PFAULT   = 4;
  localparam int ST_WAY      = 5;
  localparam int ST_RDTAG    = 8;
  localparam int VALID_BIT   = 3;
  localparam logic CFG_VALID_RST = 1'b1;
  localparam logic [12:0] INDEX_RST = 13'h0000;
  localparam logic [3:0]  TAG_RST   = 4'h0;

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NOP     = 3'h0,
    OP_COMPARE = 3'h1,
    OP_WRITE   = 3'h2,
    OP_READ    = 3'h3,
    OP_CLEAR   = 3'h4,
    OP_MRESET  = 3'h5
  } tcl_op_t;
endpackage

// *** tcl_sync_if.sv ***
// Interface carrying device pin levels into the synchroniser and out again
`timescale 1ns/1ps
interface tcl_sync_if;
  logic [7:0] pins;  // Raw pin levels
  logic [7:0] sync;  // Synchronised levels
  modport src (output pins, input sync);
  modport snk (input pins, output sync);
endinterface

// *** tcl_sync.sv ***
// Two-stage synchroniser for the device's output pins
`timescale 1ns/1ps
module tcl_sync (
  input  wire logic clk_sys,
  input  wire logic resetn,
  tcl_sync_if.snk   sif
);
  logic [7:0] stage1;
  logic [7:0] stage2;
  logic [7:0] next_stage1;
  logic [7:0] next_stage2;

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  // Next values: the first stage feeds only the second
  always_comb begin
    next_stage1 = sif.pins;
    next_stage2 = stage1;
  end

  // Registers, idle value is all high like the pulled-up pins
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stage1 <= 8'hff;
      stage2 <= 8'hff;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign sif.sync = stage2;
endmodule

// *** tcl_host_props.sv ***
// Checker of the host controller's pin discipline toward the comparator
`timescale 1ns/1ps
module tcl_host_props (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic [12:0] index_in,
  input wire logic [3:0]  tag_bus_out,
  input wire logic        tag_bus_oe,
  input wire logic        chip_enable_n,
  input wire logic        output_enable_n,
  input wire logic        store_strobe_n,
  input wire logic        auto_way_choice,
  input wire logic        entry_clear_n,
  input wire logic        recency_update_strobe,
  input wire logic        device_reset_n,
  input wire logic        hit_way_one,
  input wire logic        hit_way_two
);
  logic init_seen;
  logic next_init_seen;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Remembers that the device has seen a master reset
  always_comb begin
    next_init_seen = init_seen | ~device_reset_n;
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      init_seen <= 1'b0;
    end else begin
      init_seen <= next_init_seen;
    end
  end
  // Steps of a store or clear pulse toward the device
  sequence s_store;
    !store_strobe_n && !chip_enable_n && tag_bus_oe && $stable(index_in);
  endsequence
  sequence s_clear;
    !entry_clear_n && !auto_way_choice && !chip_enable_n && !tag_bus_oe;
  endsequence
  a_init_reset: assert property (
    $rose(resetn) |-> ##[1:16] !device_reset_n) else $error("no device reset after release");
  a_no_early_use: assert property (
    !init_seen |-> store_strobe_n && entry_clear_n && recency_update_strobe)
    else $error("device used before master reset");
  a_mreset_pulse: assert property (
    $fell(device_reset_n) |=> !device_reset_n ##1 device_reset_n) else $error("bad reset pulse");
  a_valid_bit: assert property (
    !chip_enable_n && tag_bus_oe |-> tag_bus_out[tcl_pkg::VALID_BIT]) else $error("valid bit low");
  a_ram_read: assert property (
    !chip_enable_n && !output_enable_n && !tag_bus_oe
    |-> !auto_way_choice && entry_clear_n && recency_update_strobe) else $error("bad read mode");
  a_lru_settled: assert property (
    $fell(recency_update_strobe) |-> $past(chip_enable_n, 3) == 1'b0
    && $past(index_in, 3) == index_in) else $error("recency strobe before settle");
  a_lru_on_hit: assert property (
    $fell(recency_update_strobe) |-> hit_way_one || hit_way_two) else $error("strobe on miss");
  a_store_pulse: assert property (
    $fell(store_strobe_n) |-> s_store ##1 s_store ##1 store_strobe_n) else $error("bad store");
  a_clear_pulse: assert property (
    $fell(entry_clear_n) |-> s_clear ##1 s_clear ##1 entry_clear_n) else $error("bad clear");
endmodule
bind tcl_host tcl_host_props tcl_host_props_i (.clk_sys, .resetn, .index_in, .tag_bus_out,
  .tag_bus_oe, .chip_enable_n, .output_enable_n, .store_strobe_n, .auto_way_choice,
  .entry_clear_n, .recency_update_strobe, .device_reset_n, .hit_way_one, .hit_way_two);

// *** tcl_dev_model.sv ***
// Behavioural model of the two-way tag comparator device
`timescale 1ns/1ps
module tcl_dev_model (
  input  wire logic [12:0] index_in,
  input  wire logic [3:0]  tag_bus,
  input  wire logic        chip_enable_n,
  input  wire logic        output_enable_n,
  input  wire logic        store_strobe_n,
  input  wire logic        auto_way_choice,
  input  wire logic        way_select_input,
  input  wire logic        entry_clear_n,
  input  wire logic        recency_update_strobe,
  input  wire logic        device_reset_n,
  output logic      [3:0]  dev_tag,
  output logic             dev_oe,
  output logic             hit_way_one,
  output logic             hit_way_two,
  output logic             parity_fault_n,
  output logic             way_indicator
);
  logic [4:0] way1 [8192];
  logic [4:0] way2 [8192];
  logic       lru  [8192];
  logic [4:0] e1, e2, want;
  logic       cmp, held, ws;
  // zero tag with odd parity, plain recency bit
  always @(negedge device_reset_n) begin
    for (int i = 0; i < 8192; i++) begin
      way1[i] = 5'h10;
      way2[i] = 5'h10;
      lru[i]  = 1'b0;
    end
  end
  always @(negedge store_strobe_n) begin
    if (!chip_enable_n && device_reset_n) begin
      held = lru[index_in];
      ws   = auto_way_choice ? held : way_select_input;
      want = {(~^tag_bus) ^ !output_enable_n, tag_bus};
      if (ws) begin
        way2[index_in] = want;
      end else begin
        way1[index_in] = want;
      end
      lru[index_in] = ~ws;
    end
  end
  // entry clear points recency at it
  always @(negedge entry_clear_n or negedge auto_way_choice) begin
    if (!entry_clear_n && !auto_way_choice && !chip_enable_n && device_reset_n) begin
      if (way_select_input) begin
        way2[index_in] = 5'h10;
      end else begin
        way1[index_in] = 5'h10;
      end
      lru[index_in] = way_select_input;
    end
  end
  always @(negedge recency_update_strobe) begin
    if (cmp && (hit_way_one || hit_way_two)) begin
      lru[index_in] = hit_way_one && !hit_way_two;
    end
  end
  // outputs
  // Hit and fault lines are open drain: released reads high by pull-up
  always_comb begin
    cmp = device_reset_n && !chip_enable_n && store_strobe_n && output_enable_n
          && (entry_clear_n || auto_way_choice);
    e1 = way1[index_in];
    e2 = way2[index_in];
    hit_way_one    = !cmp || (^e1 && e1 == {~^tag_bus, tag_bus});
    hit_way_two    = !cmp || (^e2 && e2 == {~^tag_bus, tag_bus});
    parity_fault_n = !(cmp && !(^e1 && ^e2));
    dev_oe  = device_reset_n && !chip_enable_n && !output_enable_n && store_strobe_n
              && entry_clear_n;
    dev_tag = way_select_input ? e2[3:0] : e1[3:0];
    way_indicator = !device_reset_n || chip_enable_n || (store_strobe_n ? lru[index_in] : held);
  end
endmodule

// *** tb.sv ***
// Self-checking bench for the tag comparator host controller
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  localparam logic [6:0]  CMP  = 7'(tcl_pkg::OP_COMPARE);
  localparam logic [6:0]  WRT  = 7'(tcl_pkg::OP_WRITE);
  localparam logic [6:0]  RDT  = 7'(tcl_pkg::OP_READ);
  localparam logic [6:0]  CLR  = 7'(tcl_pkg::OP_CLEAR);
  localparam logic [6:0]  MRS  = 7'(tcl_pkg::OP_MRESET);
  localparam logic [6:0]  AUTO = 7'h08;
  localparam logic [6:0]  WAY2 = 7'h10;
  localparam logic [6:0]  BADP = 7'h20;
  localparam logic [6:0]  UPD  = 7'h40;
  localparam logic [12:0] IX   = 13'h0010;
  localparam logic [12:0] IY   = 13'h0000;
  localparam logic [12:0] KX   = 13'h1fff;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata, st;
  logic [12:0] index_in;
  logic [3:0]  tag_bus_out, dev_tag;
  logic [3:0]  last_tag = 4'h0;
  wire  [3:0]  tag_bus;
  logic        tag_bus_oe, dev_oe, chip_enable_n, output_enable_n, store_strobe_n;
  logic        auto_way_choice, way_select_input, entry_clear_n, recency_update_strobe;
  logic        device_reset_n, hit_way_one, hit_way_two, parity_fault_n, way_indicator;
  int          fail_count = 0;
  int          checked = 0;
  int          cyc = 0;
  // Clock and tag bus; a released bus shows the inverse of its last value
  always #50 clk_sys = ~clk_sys;
  assign tag_bus = tag_bus_oe ? tag_bus_out : dev_oe ? dev_tag : ~last_tag;
  always @(posedge clk_sys) if (tag_bus_oe || dev_oe) last_tag <= tag_bus;
  tcl_host tcl_host_i (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .index_in, .tag_bus_out, .tag_bus_oe, .tag_bus_in(tag_bus), .chip_enable_n,
    .output_enable_n, .store_strobe_n, .auto_way_choice, .way_select_input, .entry_clear_n,
    .recency_update_strobe, .device_reset_n, .hit_way_one, .hit_way_two, .parity_fault_n,
    .way_indicator);
  tcl_dev_model tcl_dev_model_i (.index_in, .tag_bus, .chip_enable_n, .output_enable_n,
    .store_strobe_n, .auto_way_choice, .way_select_input, .entry_clear_n,
    .recency_update_strobe, .device_reset_n, .dev_tag, .dev_oe, .hit_way_one, .hit_way_two,
    .parity_fault_n, .way_indicator);
  // Verdict and end of run
  task automatic report_and_stop();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Cuts a hang short
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // Register port write and read
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
  // One device operation, then waits for the controller to go idle
  task automatic op(input logic [12:0] ix, input logic [3:0] tg, input logic [6:0] c);
    int n;
    wr(tcl_pkg::REG_INDEX, {19'h0, ix});
    wr(tcl_pkg::REG_TAG, {28'h0, tg});
    wr(tcl_pkg::REG_CMD, {25'h0, c});
    repeat (2) @(posedge clk_sys);
    n = 0;
    do begin
      rd(tcl_pkg::REG_STATUS, st);
      n++;
    end while (st[tcl_pkg::ST_BUSY] !== 1'b0 && n < 100);
    // A controller that never goes idle counts as a mismatch
    if (st[tcl_pkg::ST_BUSY] !== 1'b0) fail_count++;
  endtask
  // Fault, hit two and hit one from the last status
  function automatic logic [2:0] res();
    return {st[tcl_pkg::ST_PFAULT], st[tcl_pkg::ST_HIT2], st[tcl_pkg::ST_HIT1]};
  endfunction
  // Start-up: init, unmapped read, cleared entries miss
  task automatic t_init();
    int n;
    n = 0;
    do begin
      rd(tcl_pkg::REG_STATUS, st);
      n++;
    end while (st[tcl_pkg::ST_INITDONE] !== 1'b1 && n < 50);
    `CHK(st[tcl_pkg::ST_INITDONE], 1'b1)
    rd(8'h20, st);
    `CHK(st, 32'h0)
    op(IX, 4'h0, CMP);
    `CHK(res(), 3'b000)
  endtask
  // Automatic writes alternate ways, recency update, both-hit case
  task automatic t_auto();
    op(IX, 4'h1, WRT | AUTO);
    `CHK(st[tcl_pkg::ST_WAY], 1'b0)
    op(IX, 4'h2, WRT | AUTO);
    `CHK(st[tcl_pkg::ST_WAY], 1'b1)
    op(IX, 4'h1, CMP | UPD);
    `CHK(res(), 3'b001)
    op(IX, 4'h3, WRT | AUTO);
    `CHK(st[tcl_pkg::ST_WAY], 1'b1)
    op(IX, 4'h2, CMP);
    `CHK(res(), 3'b000)
    op(IY, 4'h5, WRT | WAY2);
    op(IY, 4'h5, WRT);
    op(IY, 4'h5, CMP | UPD);
    `CHK(res(), 3'b011)
    op(IY, 4'h6, WRT | AUTO);
    `CHK(st[tcl_pkg::ST_WAY], 1'b0)
  endtask
  // Entry clear, then automatic write lands in the cleared way
  task automatic t_clear();
    op(IX, 4'h0, CLR | WAY2);
    op(IX, 4'h3, CMP);
    `CHK(res(), 3'b000)
    op(IX, 4'h4, WRT | AUTO);
    `CHK(st[tcl_pkg::ST_WAY], 1'b1)
    op(IX, 4'h4, CMP);
    `CHK(res(), 3'b010)
  endtask
  // Forced bad parity, reads of both ways, then master reset
  task automatic t_parity();
    op(KX, 4'h6, WRT | BADP);
    op(KX, 4'h7, WRT | WAY2);
    op(KX, 4'h7, CMP);
    `CHK(res(), 3'b110)
    op(KX, 4'h0, RDT);
    `CHK(st[11:8], 4'he)
    op(KX, 4'h0, RDT | WAY2);
    `CHK(st[11:8], 4'hf)
    op(KX, 4'h0, MRS);
    op(KX, 4'h0, RDT | WAY2);
    `CHK(st[11:8], 4'h0)
    op(IX, 4'h1, CMP);
    `CHK(res(), 3'b000)
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    t_init();
    t_auto();
    t_clear();
    t_parity();
    report_and_stop();
  end
endmodule
